// *** logic/cdtu_threshold_unit.sv ***
// cdtu_threshold_unit: window comparison, result registers and options for card presence detection
// assumes a plain register port and measurement samples synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module cdtu_threshold_unit
	import cdtu_pkg::*;
#(
	parameter bit HAS_OPTIONS = 1'b1,
	parameter int WIDTH       = 6
)
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// register port
	input  wire logic [7:0]       regAddr,
	input  wire logic [7:0]       regWrData,
	input  wire logic             regWrite,
	input  wire logic             regRead,
	output logic      [7:0]       regRdData,
	// measurement from the analog front end
	input  wire logic             measStart,
	input  wire logic             measSampleValid,
	input  wire logic [WIDTH-1:0] measI,
	input  wire logic [WIDTH-1:0] measQ,
	input  wire logic             measDone,
	// detection flag and its clear from the interrupt status logic
	input  wire logic             detectIrqFlagClear,
	output logic                  detectIrqFlag,
	// front end controls
	output logic                  fullDriveSelect,
	output logic                  filterActive
);
	// stored registers
	logic [7:0]       qLowerReg;        // q lower border plus upper I bits 5,4
	logic [7:0]       qUpperReg;        // q upper border plus upper I bits 3,2
	logic [7:0]       iLowerReg;        // i lower border plus upper I bits 1,0
	logic [WIDTH-1:0] iResultReg;       // last I measurement value
	logic [WIDTH-1:0] qResultReg;       // last Q measurement value
	logic             muteReg;          // detection irq mute
	logic             fullDriveReg;     // full drive select
	logic             filterReg;        // noise filter enable
	logic             qUnsteadyReg;     // Q instability flag
	logic             iUnsteadyReg;     // I instability flag
	logic             irqFlagReg;       // card detection flag
	logic [7:0]       rdDataReg;        // read data, one cycle after strobe
	cdtu_meas_type    measStateReg;     // sequencer state
	cdtu_meas_type    measStateNext;

	// filter outputs
	wire [WIDTH-1:0] iFiltered;
	wire [WIDTH-1:0] qFiltered;
	wire             iUnsteady;
	wire             qUnsteady;

	// assembled upper I limit, msb first
	wire [WIDTH-1:0] iUpperLimit = {qLowerReg[7:6], qUpperReg[7:6], iLowerReg[7:6]};
	wire [WIDTH-1:0] qUpperLimit = qUpperReg[LIMIT_MSB:0];
	wire [WIDTH-1:0] iLowerLimit = iLowerReg[LIMIT_MSB:0];
	wire [WIDTH-1:0] qLowerLimit = qLowerReg[LIMIT_MSB:0];

	// decision values: filtered only when the filter is on and options exist
	wire             filterOn  = HAS_OPTIONS && filterReg;
	wire [WIDTH-1:0] iDecision = filterOn ? iFiltered : measI;
	wire [WIDTH-1:0] qDecision = filterOn ? qFiltered : measQ;

	// window comparisons
	wire iAbove    = iDecision > iUpperLimit;
	wire qAbove    = qDecision > qUpperLimit;
	wire iBelow    = iDecision < iLowerLimit;
	wire qBelow    = qDecision < qLowerLimit;
	wire outOfWin  = iAbove || qAbove || iBelow || qBelow;

	// sequencer timing
	wire evalNow   = (measStateReg == MEAS_SAMPLE) && measDone;
	wire raiseIrq  = evalNow && outOfWin && !muteReg;

	// register decode
	wire optSel    = HAS_OPTIONS && (regAddr == OPTIONS_ADDR);
	wire wrQLower  = regWrite && (regAddr == Q_LOWER_ADDR);
	wire wrQUpper  = regWrite && (regAddr == Q_UPPER_ADDR);
	wire wrILower  = regWrite && (regAddr == I_LOWER_ADDR);
	wire wrQResult = regWrite && (regAddr == Q_RESULT_ADDR);
	wire wrOptions = regWrite && optSel;

	// read mux; unmapped and reserved read as zero
	logic [7:0] rdMux;
	always_comb
	begin
		rdMux = 8'h00;
		case (regAddr)
			OPTIONS_ADDR  : rdMux = optSel ? {4'h0, fullDriveReg, filterReg, qUnsteadyReg, iUnsteadyReg} : 8'h00;
			Q_LOWER_ADDR  : rdMux = qLowerReg;
			Q_UPPER_ADDR  : rdMux = qUpperReg;
			I_LOWER_ADDR  : rdMux = iLowerReg;
			I_RESULT_ADDR : rdMux = {2'b00, iResultReg};
			Q_RESULT_ADDR : rdMux = {1'b0, muteReg, qResultReg};
			default       : rdMux = 8'h00;
		endcase
	end

	// sequencer next state
	always_comb
	begin
		measStateNext = measStateReg;
		case (measStateReg)
			MEAS_IDLE   : if (measStart) measStateNext = MEAS_SAMPLE;
			MEAS_SAMPLE : if (measDone) measStateNext = MEAS_EVAL;
			MEAS_EVAL   : measStateNext = MEAS_IDLE;
			default     : measStateNext = MEAS_IDLE;
		endcase
	end

	// per-channel filters share one window
	cdtu_sample_filter #(.WIDTH(WIDTH)) iFilter
	(
		.ref_clk       (ref_clk),
		.rst           (rst),
		.windowStart   (measStart),
		.sampleValid   (measSampleValid),
		.sampleValue   (measI),
		.filteredValue (iFiltered),
		.unsteady      (iUnsteady)
	);
	cdtu_sample_filter #(.WIDTH(WIDTH)) qFilter
	(
		.ref_clk       (ref_clk),
		.rst           (rst),
		.windowStart   (measStart),
		.sampleValid   (measSampleValid),
		.sampleValue   (measQ),
		.filteredValue (qFiltered),
		.unsteady      (qUnsteady)
	);

	// software registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			qLowerReg    <= BORDER_RESET;
			qUpperReg    <= BORDER_RESET;
			iLowerReg    <= BORDER_RESET;
			fullDriveReg <= 1'b0;
			filterReg    <= 1'b0;
			rdDataReg    <= 8'h00;
		end
		else
		begin
			if (wrQLower) qLowerReg <= regWrData;
			if (wrQUpper) qUpperReg <= regWrData;
			if (wrILower) iLowerReg <= regWrData;
			if (wrOptions)
			begin
				fullDriveReg <= regWrData[FULL_DRIVE_BIT];
				filterReg    <= regWrData[FILTER_BIT];
			end
			rdDataReg <= regRead ? rdMux : 8'h00;
		end
	end

	// mute: software sets it, a new detection procedure releases it
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			muteReg <= 1'b0;
		else if (measStart && measStateReg == MEAS_IDLE)
			muteReg <= 1'b0;
		else if (wrQResult)
			muteReg <= regWrData[MUTE_BIT];
	end

	// results and flags update together at measurement end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			iResultReg   <= RESULT_RESET;
			qResultReg   <= RESULT_RESET;
			qUnsteadyReg <= 1'b0;
			iUnsteadyReg <= 1'b0;
			measStateReg <= MEAS_IDLE;
		end
		else
		begin
			measStateReg <= measStateNext;
			if (evalNow)
			begin
				iResultReg   <= iDecision;
				qResultReg   <= qDecision;
				qUnsteadyReg <= filterOn && qUnsteady;
				iUnsteadyReg <= filterOn && iUnsteady;
			end
		end
	end

	// detection flag: a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			irqFlagReg <= 1'b0;
		else if (raiseIrq)
			irqFlagReg <= 1'b1;
		else if (detectIrqFlagClear || (wrQResult && regWrData[MUTE_BIT]))
			irqFlagReg <= 1'b0;
	end

	assign regRdData       = rdDataReg;
	assign detectIrqFlag   = irqFlagReg;
	assign fullDriveSelect = fullDriveReg;
	assign filterActive    = filterReg;

	// checks; the assembly checks follow a write into the limit, not the wiring itself
	chk_upper_assembly: assert property (@(posedge ref_clk) disable iff (rst)
		wrQUpper |=> iUpperLimit[3:2] == $past(regWrData[7:6]))
		else $error("upper I limit middle bits wrong");
	chk_upper_low_bits: assert property (@(posedge ref_clk) disable iff (rst)
		wrILower |=> iUpperLimit[1:0] == $past(regWrData[7:6]))
		else $error("upper I limit low bits wrong");
	chk_upper_top_bits: assert property (@(posedge ref_clk) disable iff (rst)
		wrQLower |=> iUpperLimit[5:4] == $past(regWrData[7:6]))
		else $error("upper I limit top bits wrong");
	chk_irq_on_high_i: assert property (@(posedge ref_clk) disable iff (rst)
		evalNow && iAbove && !muteReg |=> detectIrqFlag)
		else $error("I above limit did not raise flag");
	chk_irq_on_high_q: assert property (@(posedge ref_clk) disable iff (rst)
		evalNow && qAbove && !muteReg |=> detectIrqFlag)
		else $error("Q above limit did not raise flag");
	chk_irq_on_low_i: assert property (@(posedge ref_clk) disable iff (rst)
		evalNow && iBelow && !muteReg |=> detectIrqFlag)
		else $error("I below limit did not raise flag");
	chk_irq_on_low_q: assert property (@(posedge ref_clk) disable iff (rst)
		evalNow && qBelow && !muteReg |=> detectIrqFlag)
		else $error("Q below limit did not raise flag");
	chk_flag_has_cause: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(detectIrqFlag) |-> $past(evalNow) && $past(outOfWin))
		else $error("flag set without out-of-window evaluation");
	chk_mute_blocks_irq: assert property (@(posedge ref_clk) disable iff (rst)
		muteReg && !detectIrqFlag && !measStart |=> !detectIrqFlag)
		else $error("flag set while muted");
	chk_result_read: assert property (@(posedge ref_clk) disable iff (rst)
		regRead && regAddr == I_RESULT_ADDR |=> regRdData == {2'b00, $past(iResultReg)})
		else $error("I result readback wrong");
	chk_qresult_read: assert property (@(posedge ref_clk) disable iff (rst)
		regRead && regAddr == Q_RESULT_ADDR |=> regRdData[7] == 1'b0)
		else $error("Q result reserved bit set");
	chk_drive_write: assert property (@(posedge ref_clk) disable iff (rst)
		wrOptions |=> fullDriveSelect == $past(regWrData[FULL_DRIVE_BIT]))
		else $error("full drive select not updated");
	chk_unsteady_filter: assert property (@(posedge ref_clk) disable iff (rst)
		evalNow && !filterOn |=> !qUnsteadyReg && !iUnsteadyReg)
		else $error("instability flag without filter");
	chk_no_options: assert property (@(posedge ref_clk) disable iff (rst)
		!HAS_OPTIONS && regRead && regAddr == OPTIONS_ADDR |=> regRdData == 8'h00)
		else $error("options visible in older variant");
	chk_result_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!evalNow |=> $stable(iResultReg) && $stable(qResultReg))
		else $error("result changed outside evaluation");
endmodule : cdtu_threshold_unit
`default_nettype wire

// *** pkg/cdtu_pkg.sv ***
// cdtu_pkg: register map, field positions, reset values and timing for the card presence detect threshold unit
// assumes a byte-wide register port and a 25 MHz system clock
package cdtu_pkg;
	// register offsets (byte addresses on the plain port)
	localparam logic [7:0] OPTIONS_ADDR   = 8'h3A;
	localparam logic [7:0] Q_LOWER_ADDR   = 8'h3F;
	localparam logic [7:0] Q_UPPER_ADDR   = 8'h40;
	localparam logic [7:0] I_LOWER_ADDR   = 8'h41;
	localparam logic [7:0] I_RESULT_ADDR  = 8'h42;
	localparam logic [7:0] Q_RESULT_ADDR  = 8'h43;
	// field positions
	localparam int LIMIT_MSB      = 5;
	localparam int MUTE_BIT       = 6;
	localparam int FULL_DRIVE_BIT = 3;
	localparam int FILTER_BIT     = 2;
	localparam int Q_UNSTEADY_BIT = 1;
	localparam int I_UNSTEADY_BIT = 0;
	// reset values
	localparam logic [7:0] BORDER_RESET = 8'h00;
	localparam logic [5:0] RESULT_RESET = 6'h00;
	// timing
	localparam int CLK_FREQ_MHZ      = 25;
	localparam int FILTER_SAMPLE_NS  = 4720;
	// longest filtered sampling time, rounded down to whole cycles
	localparam int FILTER_SAMPLE_CYC = (FILTER_SAMPLE_NS * CLK_FREQ_MHZ) / 1000;
	// measurement sequencer states, one bit changes per step except the return from MEAS_EVAL to MEAS_IDLE
	typedef enum logic [1:0]
	{
		MEAS_IDLE   = 2'b00,
		MEAS_SAMPLE = 2'b01,
		MEAS_EVAL   = 2'b11
	} cdtu_meas_type;
endpackage : cdtu_pkg

// *** logic/cdtu_sample_filter.sv ***
// cdtu_sample_filter: tracks one converter channel across a measuring window
// assumes start and sample strobes come from the measurement sequencer
`timescale 1ns/100ps
`default_nettype none
module cdtu_sample_filter
	import cdtu_pkg::*;
#(
	parameter int WIDTH = 6
)
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// control
	input  wire logic             windowStart,
	input  wire logic             sampleValid,
	input  wire logic [WIDTH-1:0] sampleValue,
	// results
	output logic      [WIDTH-1:0] filteredValue,
	output logic                  unsteady
);
	logic [WIDTH-1:0] firstReg;     // first sample of the window
	logic [WIDTH+1:0] sumReg;       // running sum of two latest samples
	logic [WIDTH-1:0] lastReg;      // most recent sample
	logic             haveReg;      // a sample was taken in this window
	logic             unsteadyReg;  // any sample differed from the first
	wire  [WIDTH:0]   pairSum = {1'b0, lastReg} + {1'b0, sampleValue};

	// average of the two latest samples smooths single-sample spikes
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			firstReg    <= '0;
			sumReg      <= '0;
			lastReg     <= '0;
			haveReg     <= 1'b0;
			unsteadyReg <= 1'b0;
		end
		else if (windowStart)
		begin
			haveReg     <= 1'b0;
			unsteadyReg <= 1'b0;
		end
		else if (sampleValid)
		begin
			lastReg <= sampleValue;
			haveReg <= 1'b1;
			// first sample seeds both halves of the average
			if (!haveReg)
			begin
				firstReg <= sampleValue;
				sumReg   <= {1'b0, sampleValue, 1'b0};
			end
			else
			begin
				sumReg <= {1'b0, pairSum};
				if (sampleValue != firstReg)
					unsteadyReg <= 1'b1;
			end
		end
	end

	assign filteredValue = sumReg[WIDTH:1];
	assign unsteady      = unsteadyReg;
endmodule : cdtu_sample_filter
`default_nettype wire

// *** tb/cdtu_threshold_unit_bench.sv ***
// cdtu_threshold_unit_bench: self-checking bench for the detection threshold unit
// assumes the unit answers reads one cycle late and updates the flag one cycle after measDone
`timescale 1ns/100ps
`default_nettype none
module cdtu_threshold_unit_bench;
	import cdtu_pkg::*;
	logic       ref_clk, rst, regWrite, regRead, rdPend;
	logic [7:0] regAddr, regWrData, regRdData, v;
	logic       measStart, measSampleValid, measDone, detectIrqFlagClear;
	logic       detectIrqFlag, fullDriveSelect, filterActive;
	logic [5:0] measI, measQ;
	logic [7:0] expQ[$];                 // expected read data, oldest first
	logic [7:0] addrs[7] = '{8'h3A, 8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h50};
	logic [5:0] ci[8]    = '{6'h19, 6'h29, 6'h28, 6'h09, 6'h0A, 6'h14, 6'h14, 6'h14};
	logic [5:0] cq[8]    = '{6'h1E, 6'h14, 6'h14, 6'h14, 6'h14, 6'h29, 6'h28, 6'h09};
	logic       cf[8]    = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	int         fail_count = 0;
	int         checked = 0;
	// borders: I window 10..40, Q window 10..40
	localparam logic [5:0] ILO = 6'd10, IHI = 6'd40, QLO = 6'd10, QHI = 6'd40;
	cdtu_threshold_unit dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .measStart(measStart),
		.measSampleValid(measSampleValid), .measI(measI), .measQ(measQ), .measDone(measDone),
		.detectIrqFlagClear(detectIrqFlagClear), .detectIrqFlag(detectIrqFlag),
		.fullDriveSelect(fullDriveSelect), .filterActive(filterActive));
	// clock, 40 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	// read data is sampled at the falling edge, away from the launching edge
	always @(negedge ref_clk)
	begin
		if (rdPend)
		begin
			if (expQ.size() == 0)
				check(8'h00, 8'hFF, "read with no expectation");
			else
				check(regRdData, expQ.pop_front(), "read data");
		end
		rdPend = regRead;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
	endtask : rd
	// one detection: start, two samples, done; optional mute write mid-window; then clear the flag
	task automatic meas(input logic [5:0] i0, i1, q0, q1, input logic mute, input logic ef);
		@(posedge ref_clk);
		measStart <= 1'b1;
		@(posedge ref_clk);
		measStart <= 1'b0;
		measSampleValid <= 1'b1;
		measI <= i0;
		measQ <= q0;
		regAddr <= Q_RESULT_ADDR;
		regWrData <= 8'h40;
		regWrite <= mute;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		measI <= i1;
		measQ <= q1;
		@(posedge ref_clk);
		measSampleValid <= 1'b0;
		measDone <= 1'b1;
		// a clear in the evaluation cycle must lose against a new detection
		detectIrqFlagClear <= ef;
		@(posedge ref_clk);
		measDone <= 1'b0;
		detectIrqFlagClear <= 1'b0;
		@(negedge ref_clk);
		check({7'h00, detectIrqFlag}, {7'h00, ef}, "detection flag");
		@(posedge ref_clk);
		detectIrqFlagClear <= 1'b1;
		@(posedge ref_clk);
		detectIrqFlagClear <= 1'b0;
		@(negedge ref_clk);
		check({7'h00, detectIrqFlag}, 8'h00, "flag after clear");
	endtask : meas
	// a hang is cut short here
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		results();
	end
	initial
	begin
		{rst, regWrite, regRead, rdPend, measStart, measSampleValid, measDone} = 7'h7F ^ 7'h3F;
		{regAddr, regWrData, measI, measQ, detectIrqFlagClear} = '0;
		void'($urandom(32'h94730bf7));
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		// reset values, plus an unmapped address reading zero
		foreach (addrs[k]) rd(addrs[k], 8'h00);
		// borders read back what was written
		foreach (addrs[k])
		begin
			if (addrs[k] inside {Q_LOWER_ADDR, Q_UPPER_ADDR, I_LOWER_ADDR})
			begin
				v = 8'($urandom());
				wr(addrs[k], v);
				rd(addrs[k], v);
			end
		end
		// results are read-only; bit 6 of the Q result is the writable mute
		wr(I_RESULT_ADDR, 8'hFF);
		rd(I_RESULT_ADDR, 8'h00);
		wr(Q_RESULT_ADDR, 8'hFF);
		rd(Q_RESULT_ADDR, 8'h40);
		// the I upper limit is spread over the top bits of three registers
		wr(Q_LOWER_ADDR, {IHI[5:4], QLO});
		wr(Q_UPPER_ADDR, {IHI[3:2], QHI});
		wr(I_LOWER_ADDR, {IHI[1:0], ILO});
		// window edges; the first sample differs so an unwanted filter shows
		ci[0] = 6'(11 + $urandom() % 29);
		foreach (ci[k])
		begin
			meas(ci[k] ^ 6'h15, ci[k], cq[k] ^ 6'h2A, cq[k], 1'b0, cf[k]);
			rd(I_RESULT_ADDR, {2'b00, ci[k]});
			rd(Q_RESULT_ADDR, {2'b00, cq[k]});
		end
		// mute written inside the window suppresses the out-of-window result
		meas(6'd20, 6'd20, 6'd50, 6'd50, 1'b1, 1'b0);
		rd(Q_RESULT_ADDR, 8'h72);
		// options: drive level and filter enable, read-only flag bits stay
		wr(OPTIONS_ADDR, 8'hFF);
		@(negedge ref_clk);
		check({6'h00, fullDriveSelect, filterActive}, 8'h03, "option outputs");
		rd(OPTIONS_ADDR, 8'h0C);
		meas(6'd20, 6'd22, 6'd30, 6'd30, 1'b0, 1'b0);
		rd(I_RESULT_ADDR, 8'd21);
		rd(OPTIONS_ADDR, 8'h0D);
		meas(6'd30, 6'd42, 6'd30, 6'd30, 1'b0, 1'b0);
		meas(6'd40, 6'd44, 6'd30, 6'd30, 1'b0, 1'b1);
		meas(6'd20, 6'd20, 6'd40, 6'd44, 1'b0, 1'b1);
		rd(OPTIONS_ADDR, 8'h0E);
		wr(OPTIONS_ADDR, 8'h00);
		@(negedge ref_clk);
		check({6'h00, fullDriveSelect, filterActive}, 8'h00, "option outputs");
		repeat (3) @(posedge ref_clk);
		check(8'(expQ.size()), 8'h00, "reads left unanswered");
		results();
	end
endmodule : cdtu_threshold_unit_bench
`default_nettype wire
